// ### hdl/pors_pkg.sv
package pors_pkg;
   // ----------------------------------------------------------------
   // Register map (APB byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CAUSE = 8'h04;
   localparam logic [7:0] ADDR_PC = 8'h08;
   localparam logic [7:0] ADDR_SFR = 8'h10;
   localparam logic [7:0] ADDR_CFG = 8'h14;
   // Status field positions and values
   localparam int TIMEOUT_FLAG_BIT = 4;
   localparam int POWERDOWN_FLAG_BIT = 3;
   localparam logic [7:0] STATUS_POR = 8'h18;
   localparam logic [12:0] PC_ZERO = 13'h0000;
   localparam logic [12:0] PC_VECTOR = 13'h0004;
   localparam logic [7:0] OPTION_RST = 8'hff;
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [4:0] UPC_RST = 5'h00;
   localparam int IRQ_KEEP_BIT = 0;
   // Oscillator modes
   typedef enum logic [1:0] {
      PORS_OSC_LOWPWR = 2'b00,
      PORS_OSC_CRYSTAL = 2'b01,
      PORS_OSC_HIGHSPD = 2'b10,
      PORS_OSC_RC = 2'b11
   } pors_osc_t;
   // Reset cause codes
   typedef enum logic [2:0] {
      PORS_C_NONE = 3'd0,
      PORS_C_POR = 3'd1,
      PORS_C_CLEAR_RUN = 3'd2,
      PORS_C_CLEAR_SLEEP = 3'd3,
      PORS_C_WDOG_RUN = 3'd4,
      PORS_C_WDOG_WAKE = 3'd5,
      PORS_C_IRQ_WAKE = 3'd6
   } pors_cause_t;
   // Timing
   localparam int POWERUP_MS = 72;
   localparam int OSC_START_CYCLES = 1024;
   localparam int RC_CLK_HZ = 10000;
   localparam int POWERUP_RC_TICKS = POWERUP_MS * RC_CLK_HZ / 1000;
   // Core-side register image
   typedef struct packed {
      logic [12:0] pc;
      logic [7:0] status;
      logic [7:0] option;
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [4:0] upper_pc_latch;
      logic [7:0] irq_control_reg;
   } pors_image_t;
endpackage

// ### hdl/pors_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pors_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   // ----------------------------------------------------------------
   // Two-stage synchroniser, first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // pors_sync
`default_nettype wire

// ### hdl/pors_counter.sv
`timescale 1ns/10ps
`default_nettype none
module pors_counter #(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic tick,
   input wire logic [WIDTH-1:0] limit,
   output logic busy,
   output logic done
);
   logic [WIDTH-1:0] count;
   // ----------------------------------------------------------------
   // Counts enable ticks to limit; done pulses once at expiry
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            count <= '0;
            busy <= 1'b1;
         end else if (busy && tick) begin
            if (count == limit - WIDTH'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            count <= count + WIDTH'(1);
         end
      end
   end
endmodule // pors_counter
`default_nettype wire

// ### hdl/pors_sequencer.sv
// Overview of operation
// - Power-on: PC zero, status 0001_1xxx (low bits kept, undefined).
// - Clear pin reset running: PC zero, top three status bits cleared.
// - Clear pin reset in sleep: PC zero, timeout set, powerdown cleared.
// - Watchdog reset running: PC zero, timeout cleared, powerdown set.
// - Wake: PC+1; watchdog wake clears both flags, interrupt wake sets timeout.
// - Interrupt wake with global enable: PC loads interrupt vector.
// - Non-wake resets: option and direction all ones, latch cleared, irq cleared except bit 0 kept.
// - Wake keeps registers except irq flags recording the wake event.
// - Supply rise pulse from the detector starts a power-on reset.
// - Supply fall causes no internal reset.
// - Power-up delay runs on internal RC clock after power-on pulse.
// - Core held in reset while power-up delay counts.
// - Power-up delay skipped when its enable configuration bit is off.
// - After power-up delay, count 1024 oscillator input cycles.
// - Oscillator count only in crystal modes, after power-on or wake.
// - Delays run from power-on pulse; late pin release starts at once.
// - RC mode with delay disabled gives no start-up delay.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pors_sequencer
   import pors_pkg::*;
#(
   parameter int PWRUP_TICKS = POWERUP_RC_TICKS,
   parameter int OSC_START_COUNT = OSC_START_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic supply_rise,
   input wire logic master_clear_pin_n,
   input wire logic watchdog_unit_timeout,
   input wire logic irq_wake,
   input wire logic [7:0] irq_wake_flags,
   input wire logic rc_osc_clk,
   input wire logic osc_input_pin,
   input wire logic sleep_entry,
   input wire logic [12:0] core_pc,
   input wire logic [7:0] core_status_in,
   input wire logic [7:0] core_irq_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic core_reset,
   output logic load_strobe,
   output pors_pkg::pors_image_t image,
   output logic [2:0] last_cause
);
   import pors_pkg::*;

   // Both counters are 16 bits wide; longer counts cannot be served
   if (PWRUP_TICKS < 1 || PWRUP_TICKS > 65535 || OSC_START_COUNT < 1 ||
       OSC_START_COUNT > 65535) begin : g_bad_counts
      $error("pors_sequencer: counts out of range");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] raw_in;
   logic [5:0] syn;
   assign raw_in = {supply_rise, master_clear_pin_n, watchdog_unit_timeout,
                    irq_wake, rc_osc_clk, osc_input_pin};
   pors_sync #(.WIDTH(6)) u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .async_in(raw_in),
      .sync_out(syn)
   );
   wire s_rise = syn[5];
   wire s_clear_n = syn[4];
   wire s_wdog = syn[3];
   wire s_irq = syn[2];
   wire s_rc = syn[1];
   wire s_osc = syn[0];

   // Edge detectors on synchronised levels
   logic [5:0] syn_d;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) syn_d <= 6'h10;
      else syn_d <= syn;
   end
   wire rise_pulse = s_rise & ~syn_d[5];   // Only rising edge
   wire wdog_pulse = s_wdog & ~syn_d[3];
   wire irq_pulse = s_irq & ~syn_d[2];
   wire rc_tick = s_rc & ~syn_d[1];
   wire osc_tick = s_osc & ~syn_d[0];

   // ----------------------------------------------------------------
   // Software configuration
   // ----------------------------------------------------------------
   logic pwrup_en_cfg;
   pors_osc_t osc_mode;
   logic global_irq_enable;
   logic sleeping;

   wire apb_setup = psel & ~penable;
   wire apb_wr = psel & penable & pwrite & pready;
   wire hit_ctrl = paddr == ADDR_CTRL;
   wire hit_cfg = paddr == ADDR_CFG;
   wire hit_status = paddr == ADDR_STATUS;
   wire mapped = hit_ctrl | hit_cfg | hit_status |
                 (paddr == ADDR_CAUSE) | (paddr == ADDR_PC) |
                 (paddr == ADDR_SFR);
   // Crystal modes need the start-up count
   wire osc_xtal = osc_mode != PORS_OSC_RC;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pwrup_en_cfg <= 1'b1;
         osc_mode <= PORS_OSC_CRYSTAL;
         global_irq_enable <= 1'b0;
      end else if (apb_wr && hit_cfg) begin
         pwrup_en_cfg <= pwdata[0];
         osc_mode <= pors_osc_t'(pwdata[2:1]);
         global_irq_enable <= pwdata[3];
      end
   end

   // ----------------------------------------------------------------
   // Sequencer state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_PWRUP = 3'b001,
      ST_OSCWAIT = 3'b010,
      ST_HOLD = 3'b011,
      ST_LOAD = 3'b100
   } pors_state_t;
   pors_state_t state;
   pors_state_t next_state;
   pors_cause_t cause;
   logic pending_por;

   logic pw_start;
   logic pw_busy;
   logic pw_done;
   logic osc_start;
   logic osc_done;

   pors_counter #(.WIDTH(16)) u_pwrup (
      .sys_clk(sys_clk),
      .reset(reset),
      .start(pw_start),
      .tick(rc_tick),
      .limit(16'(PWRUP_TICKS)),
      .busy(pw_busy),
      .done(pw_done)
   );
   pors_counter #(.WIDTH(16)) u_oscstart (
      .sys_clk(sys_clk),
      .reset(reset),
      .start(osc_start),
      .tick(osc_tick),
      .limit(16'(OSC_START_COUNT)),
      .busy(),
      .done(osc_done)
   );

   // Wake from sleep by watchdog or interrupt
   wire wake_wdog = sleeping & wdog_pulse & (state == ST_RUN);
   wire wake_irq = sleeping & irq_pulse & (state == ST_RUN);
   wire wdog_run = ~sleeping & wdog_pulse & (state == ST_RUN);
   wire is_wake = (cause == PORS_C_WDOG_WAKE) | (cause == PORS_C_IRQ_WAKE);

   // Start the power-up delay from the pulse itself
   assign pw_start = rise_pulse & pwrup_en_cfg;
   assign osc_start = (state == ST_PWRUP && next_state == ST_OSCWAIT) ||
                      ((wake_wdog || wake_irq) && osc_xtal);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (wake_wdog || wake_irq)
               next_state = osc_xtal ? ST_OSCWAIT : ST_LOAD;
            else if (!s_clear_n || wdog_run)
               next_state = ST_HOLD;
         end
         ST_PWRUP: begin
            if (!pw_busy && !pw_start)
               next_state = osc_xtal ? ST_OSCWAIT : ST_HOLD;
         end
         ST_OSCWAIT: begin
            if (osc_done) next_state = ST_HOLD;
         end
         ST_HOLD: begin
            if (s_clear_n) next_state = ST_LOAD;
         end
         ST_LOAD: next_state = ST_RUN;
         default: next_state = ST_HOLD;
      endcase
      if (rise_pulse) next_state = ST_PWRUP;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= ST_PWRUP;
         cause <= PORS_C_POR;
         pending_por <= 1'b1;
      end else begin
         state <= next_state;
         if (rise_pulse) begin
            cause <= PORS_C_POR;
         end else if (state == ST_RUN) begin
            if (wake_wdog) cause <= PORS_C_WDOG_WAKE;
            else if (wake_irq) cause <= PORS_C_IRQ_WAKE;
            else if (!s_clear_n)
               cause <= sleeping ? PORS_C_CLEAR_SLEEP : PORS_C_CLEAR_RUN;
            else if (wdog_run) cause <= PORS_C_WDOG_RUN;
         end
         // A supply rise beats the clear, so a new power-on is not lost
         if (rise_pulse) pending_por <= 1'b1;
         else if (state == ST_LOAD) pending_por <= 1'b0;
      end
   end

   // Sleep flag follows the core
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) sleeping <= 1'b0;
      else if (state == ST_LOAD || rise_pulse) sleeping <= 1'b0;
      else if (sleep_entry && state == ST_RUN) sleeping <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Image computation per cause
   // ----------------------------------------------------------------
   logic [7:0] next_status;
   logic [12:0] next_pc;
   always_comb begin
      next_status = core_status_in;
      next_pc = PC_ZERO;
      unique case (cause)
         PORS_C_POR:
            next_status = {STATUS_POR[7:3], core_status_in[2:0]};
         PORS_C_CLEAR_RUN:
            next_status = {3'b000, core_status_in[4:0]};
         PORS_C_CLEAR_SLEEP:
            next_status = {3'b000, 1'b1, 1'b0, core_status_in[2:0]};
         PORS_C_WDOG_RUN:
            next_status = {3'b000, 1'b0, 1'b1, core_status_in[2:0]};
         PORS_C_WDOG_WAKE: begin
            next_status = core_status_in;
            next_status[TIMEOUT_FLAG_BIT] = 1'b0;
            next_status[POWERDOWN_FLAG_BIT] = 1'b0;
            next_pc = core_pc + 13'h0001;
         end
         PORS_C_IRQ_WAKE: begin
            next_status = core_status_in;
            next_status[TIMEOUT_FLAG_BIT] = 1'b1;
            next_status[POWERDOWN_FLAG_BIT] = 1'b0;
            next_pc = global_irq_enable ? PC_VECTOR
                                        : core_pc + 13'h0001;
         end
         default: next_status = core_status_in;
      endcase
   end

   // Register image loaded once per reset release
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         image <= '0;
         load_strobe <= 1'b0;
         core_reset <= 1'b1;
         last_cause <= 3'd0;
      end else begin
         load_strobe <= state == ST_LOAD;
         core_reset <= next_state != ST_RUN;
         if (state == ST_LOAD) begin
            last_cause <= cause;
            image.pc <= next_pc;
            image.status <= next_status;
            if (is_wake) begin
               // Registers kept, wake flag recorded
               image.irq_control_reg <= core_irq_in | irq_wake_flags;
            end else begin
               image.option <= OPTION_RST;
               image.dir_a <= DIR_RST;
               image.dir_b <= DIR_RST;
               image.upper_pc_latch <= UPC_RST;
               image.irq_control_reg <=
                  {7'h00, core_irq_in[IRQ_KEEP_BIT]};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   assign rd_mux =
      hit_ctrl ? {29'h0, state} :
      hit_cfg ? {28'h0, global_irq_enable, osc_mode, pwrup_en_cfg} :
      hit_status ? {24'h0, image.status} :
      (paddr == ADDR_CAUSE) ? {28'h0, pending_por, cause} :
      (paddr == ADDR_PC) ? {19'h0, image.pc} :
      (paddr == ADDR_SFR) ? {3'h0, image.upper_pc_latch, image.option,
                             image.dir_b, image.irq_control_reg} :
      32'h0;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup & ~mapped;
         if (apb_setup && !pwrite) prdata <= rd_mux;
      end
   end
endmodule // pors_sequencer
`default_nettype wire

// ### test/pors_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Port checks
// ----
module pors_seq_asserts
   import pors_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic supply_rise,
   input wire logic master_clear_pin_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic core_reset,
   input wire logic load_strobe
);
   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // Six mapped words
   wire logic mapped;
   assign mapped = paddr inside {ADDR_CTRL, ADDR_CAUSE, ADDR_PC,
                                 ADDR_STATUS, ADDR_SFR, ADDR_CFG};
   // Bus answer
   chk_pready_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   chk_pready_single: assert property (pready |=> !pready)
      else $error("pready too long");
   chk_unmapped_err: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped without error");
   chk_mapped_ok: assert property (pready && mapped |-> !pslverr)
      else $error("mapped with error");
   chk_unmapped_zero: assert property (
      pready && !mapped && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   // Sequencing
   chk_strobe_single: assert property (load_strobe |=> !load_strobe)
      else $error("load strobe too long");
   chk_release_load: assert property (
      $fell(core_reset) |->
      load_strobe || $past(load_strobe) || $past(load_strobe, 2))
      else $error("release without load");
   chk_pin_holds: assert property (
      !master_clear_pin_n [*6] |-> core_reset)
      else $error("core runs with pin low");
   chk_supply_hold: assert property (
      $rose(supply_rise) |-> ##[1:6] core_reset)
      else $error("no reset on supply rise");
   // Main scenarios seen
   cov_load: cover property (load_strobe);
   cov_err: cover property (pready && pslverr);
   cov_release: cover property ($fell(core_reset));
endmodule // pors_seq_asserts

bind pors_sequencer pors_seq_asserts chk_i (.sys_clk, .reset,
   .supply_rise, .master_clear_pin_n, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .core_reset, .load_strobe);
`default_nettype wire

// ### test/pors_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Supply detector, reset pin and oscillators
// ----
module pors_partner (
   input wire logic vdd_on,
   input wire logic limits_ok,
   output logic supply_rise,
   output logic master_clear_pin_n,
   output logic rc_osc_clk,
   output logic osc_input_pin
);
   // Detector level follows supply; only its rise means power-on
   assign supply_rise = vdd_on;
   // Board keeps pin low until conditions are good
   assign master_clear_pin_n = limits_ok;
   // Oscillators stop dead with the supply off
   initial begin
      rc_osc_clk = 1'h0;
      osc_input_pin = 1'h0;
   end
   always begin
      // Non-blocking, so an edge that meets sys_clk never races it
      #50 rc_osc_clk <= vdd_on ? ~rc_osc_clk : 1'h0;
   end
   always begin
      #30 osc_input_pin <= vdd_on ? ~osc_input_pin : 1'h0;
   end
endmodule // pors_partner
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pors_pkg::*;
   logic sys_clk, reset, vdd_on, limits_ok, supply_rise, master_clear_pin_n;
   logic rc_osc_clk, osc_input_pin, watchdog_unit_timeout, irq_wake;
   logic sleep_entry, psel, penable, pwrite, pready, pslverr, err;
   logic core_reset, load_strobe;
   logic [7:0] irq_wake_flags, core_status_in, core_irq_in, paddr;
   logic [12:0] core_pc;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] last_cause;
   pors_image_t image;
   int num_errors = 0;
   int n_checks = 0;
   int n;
   // ----
   // Design, far side, clock
   // ----
   pors_sequencer #(.PWRUP_TICKS(4), .OSC_START_COUNT(4)) DUT (
      .sys_clk, .reset, .supply_rise, .master_clear_pin_n,
      .watchdog_unit_timeout, .irq_wake, .irq_wake_flags, .rc_osc_clk,
      .osc_input_pin, .sleep_entry, .core_pc, .core_status_in,
      .core_irq_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .core_reset, .load_strobe, .image, .last_cause);
   pors_partner far_i (.vdd_on, .limits_ok, .supply_rise,
      .master_clear_pin_n, .rc_osc_clk, .osc_input_pin);
   initial sys_clk = 1'h0;
   always #10 sys_clk = ~sys_clk;
   // ----
   // Shared tasks
   // ----
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'h1) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   // Request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'h1;
      do @(posedge sys_clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wait_load(output int c);
      c = 0;
      do begin
         @(posedge sys_clk);
         c++;
      end while (load_strobe !== 1'h1 && c < 3000);
      chk(load_strobe === 1'h1, "no load strobe");
   endtask
   task automatic expect_load(input logic [12:0] pc, input logic [7:0] st,
                              input logic [2:0] cause, input logic full);
      chk(image.pc === pc && image.status === st, "pc or status");
      if (full) begin
         chk(image.option === OPTION_RST && image.dir_a === DIR_RST
             && image.dir_b === DIR_RST, "option or dir");
         chk(image.upper_pc_latch === UPC_RST
             && image.irq_control_reg[7:1] === 7'h00, "latch or irq");
      end else begin
         chk(image.irq_control_reg === (core_irq_in | irq_wake_flags)
             && image.option === OPTION_RST, "wake regs");
      end
      repeat (3) @(posedge sys_clk);
      chk(last_cause === cause && core_reset === 1'h0, "cause");
   endtask
   // Supply off and on; optional late pin release
   task automatic power_up(input int hold, output int c);
      logic up;
      up = (core_reset === 1'h0);
      vdd_on <= 1'h0;
      repeat (10) @(posedge sys_clk);
      if (up) chk(core_reset === 1'h0, "reset on supply fall");
      limits_ok <= (hold == 0);
      vdd_on <= 1'h1;
      repeat (hold) @(posedge sys_clk);
      limits_ok <= 1'h1;
      wait_load(c);
   endtask
   // Reset cause from pin (0), watchdog (1) or interrupt (2)
   task automatic ev(input logic slp, input int kind, input logic [12:0] pc,
                     input logic [7:0] st, input logic [2:0] cause,
                     input logic full);
      int c;
      if (slp) begin
         sleep_entry <= 1'h1;
         @(posedge sys_clk);
         sleep_entry <= 1'h0;
      end
      repeat (4) @(posedge sys_clk);
      if (kind == 0) begin
         limits_ok <= 1'h0;
         repeat (8) @(posedge sys_clk);
         limits_ok <= 1'h1;
      end else begin
         watchdog_unit_timeout <= (kind == 1);
         irq_wake <= (kind == 2);
         @(posedge sys_clk);
         watchdog_unit_timeout <= 1'h0;
         irq_wake <= 1'h0;
      end
      wait_load(c);
      expect_load(pc, st, cause, full);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_regs;
      apb(1'h0, ADDR_CFG, 32'h0);
      chk(rd[3:0] === 4'h3 && err === 1'h0, "cfg reset");
      apb(1'h1, 8'h20, 32'hffffffff);
      apb(1'h0, 8'h20, 32'h0);
      chk(rd === 32'h0 && err === 1'h1, "unmapped read");
      apb(1'h0, ADDR_CFG, 32'h0);
      chk(rd[3:0] === 4'h3, "cfg changed");
   endtask
   task automatic t_por;
      power_up(0, n);
      expect_load(PC_ZERO, 8'h1a, PORS_C_POR, 1'h1);
      power_up(0, n);
      chk(n >= 20, "start-up delay short");
      expect_load(PC_ZERO, 8'h1a, PORS_C_POR, 1'h1);
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk(rd[7:0] === 8'h1a, "status image");
   endtask
   task automatic t_events;
      ev(1'h0, 0, PC_ZERO, 8'h0a, PORS_C_CLEAR_RUN, 1'h1);
      ev(1'h1, 0, PC_ZERO, 8'h12, PORS_C_CLEAR_SLEEP, 1'h1);
      ev(1'h0, 1, PC_ZERO, 8'h0a, PORS_C_WDOG_RUN, 1'h1);
      ev(1'h1, 1, 13'h0124, 8'he2, PORS_C_WDOG_WAKE, 1'h0);
      ev(1'h1, 2, 13'h0124, 8'hf2, PORS_C_IRQ_WAKE, 1'h0);
      apb(1'h1, ADDR_CFG, 32'h0000000b);
      ev(1'h1, 2, PC_VECTOR, 8'hf2, PORS_C_IRQ_WAKE, 1'h0);
   endtask
   task automatic t_start_modes;
      power_up(300, n);
      chk(n <= 8, "late release slow");
      apb(1'h1, ADDR_CFG, 32'h00000006);
      power_up(0, n);
      chk(n <= 10, "delay in rc mode");
      expect_load(PC_ZERO, 8'h1a, PORS_C_POR, 1'h1);
      apb(1'h1, ADDR_CFG, 32'h00000000);
      power_up(0, n);
      chk(n >= 12 && n <= 26, "no oscillator count in lp");
      expect_load(PC_ZERO, 8'h1a, PORS_C_POR, 1'h1);
   endtask
   // ----
   // Main sequence and watchdog
   // ----
   initial begin
      reset = 1'h1;
      vdd_on = 1'h0;
      limits_ok = 1'h1;
      watchdog_unit_timeout = 1'h0;
      irq_wake = 1'h0;
      sleep_entry = 1'h0;
      irq_wake_flags = 8'h02;
      core_status_in = 8'hea;
      core_irq_in = 8'h41;
      core_pc = 13'h0123;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge sys_clk);
      reset <= 1'h0;
      t_regs();
      t_por();
      t_events();
      t_start_modes();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      $display("[ERR] %0t run too long", $time);
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
